// File: hw/power_mode_and_por_control.sv
// Power-mode control, power-on reset sequencing and reset cause capture
//
// What this block does
// RULE1 - Bits 7 to 2 of power_control are six software flags that store and read back only.
// RULE2 - Writing 1 to bit 1 of power_control enters stop mode and halts the oscillator.
// RULE3 - The stop and idle select bits always read back as 0.
// RULE4 - Writing 1 to bit 0 gates the CPU clock while peripheral clocks keep running.
// RULE5 - During power-up the device stays in reset and drives its reset pin low until supply is good.
// RULE6 - After the supply is good a power_up_release_delay passes before reset is released.
// RULE7 - Leaving a power-on reset sets the power_up_cause_flag, bit 1 of the reset source register.
// RULE8 - Any reset other than power-on clears the power_up_cause_flag.
// RULE9 - Every reset restarts execution at address 0x0000.
// RULE10 - Software treats data memory as undefined after power-on; nothing here clears it.
// RULE11 - After a power-on reset the supply monitor is enabled and chosen as a reset source.
// RULE12 - Idle ends on any taken interrupt or any reset, restoring the CPU clock.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module power_mode_and_por_control
    import power_pkg::*;
#(
    parameter int unsigned POR_DELAY = power_pkg::POR_DELAY_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [9:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    output logic             irq,
    input  wire logic        supply_ok,
    input  wire logic        other_reset,
    input  wire logic        cpu_irq_taken,
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    output logic             cpu_reset_n,
    output logic      [15:0] reset_vector,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             osc_run,
    output logic             monitor_en,
    output logic             monitor_reset_sel
);
    import power_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        bus_req;
    logic        bus_wr;
    logic [7:0]  bus_idx;
    logic [7:0]  rd_val;
    logic        wr_pc;
    logic        wr_mon;
    logic        wr_mask;
    logic        wr_stat;

    assign bus_req = wb_cyc && wb_stb && !wb_ack;
    assign bus_idx = wb_adr[9:2];
    assign bus_wr  = bus_req && wb_we && wb_sel[0];
    assign wr_pc   = bus_wr && (bus_idx == IDX_POWER_CONTROL);
    assign wr_mon  = bus_wr && (bus_idx == IDX_MONITOR_CTRL);
    assign wr_mask = bus_wr && (bus_idx == IDX_IRQ_MASK);
    assign wr_stat = bus_wr && (bus_idx == IDX_IRQ_STATUS);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    seq_state_e   state_q;
    seq_state_e   state_d;
    logic         por_kind_q;
    reset_cause_s cause_q;
    logic [5:0]   flags_q;
    logic         idle_q;
    logic         stop_q;
    logic [2:0]   mask_q;
    logic [2:0]   status_q;
    irq_evt_s     evt;
    logic         delay_done;
    logic         delay_load;
    logic         running;
    logic         mon_trip;
    logic         pin_trip;
    logic         supply_prev_q;

    assign running  = (state_q == ST_RUN);
    assign mon_trip = monitor_en && monitor_reset_sel && !supply_ok;
    // Pin is only watched once it is released, so our own drive never looks external
    assign pin_trip = !rst_pin_oe && !rst_pin_in;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_HOLD: begin
                if (supply_ok && !other_reset) begin // [RULE5]
                    state_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!supply_ok || other_reset) begin
                    state_d = ST_HOLD;
                end else if (delay_done) begin // [RULE6]
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (mon_trip || pin_trip || other_reset) begin
                    state_d = ST_HOLD;
                end
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
    end

    assign delay_load = (state_q == ST_HOLD) && (state_d == ST_DELAY);

    delay_counter #(
        .W (DELAY_W)
    ) u_delay (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (delay_load),
        .load_val (DELAY_W'(POR_DELAY)), // [RULE6]
        .done     (delay_done)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Reset pin is open drain: low while held in reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pin_out  <= 1'b0;
            rst_pin_oe   <= 1'b1;
            cpu_reset_n  <= 1'b0;
            reset_vector <= RESET_VECTOR;
        end else begin
            rst_pin_out  <= 1'b0;
            rst_pin_oe   <= (state_d != ST_RUN); // [RULE5]
            cpu_reset_n  <= (state_d == ST_RUN);
            reset_vector <= RESET_VECTOR; // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // Reset cause capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            por_kind_q <= 1'b1;
            cause_q    <= '0;
        end else if (running && state_d == ST_HOLD) begin
            por_kind_q       <= 1'b0;
            cause_q.power_up <= 1'b0; // [RULE8]
            cause_q.monitor  <= mon_trip;
            cause_q.pin      <= pin_trip;
            cause_q.other    <= other_reset;
        end else if (state_q == ST_DELAY && state_d == ST_RUN && por_kind_q) begin
            // Other causes are left as they were on a power-up
            cause_q.power_up <= 1'b1; // [RULE7]
        end
    end

    // Monitor comes back armed after power-up without software help
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            monitor_en        <= MON_RESET[MON_EN_BIT];
            monitor_reset_sel <= MON_RESET[MON_SEL_BIT];
        end else if (state_q == ST_DELAY && state_d == ST_RUN && por_kind_q) begin
            monitor_en        <= 1'b1; // [RULE11]
            monitor_reset_sel <= 1'b1; // [RULE11]
        end else if (wr_mon && running) begin
            monitor_en        <= wb_dat_w[MON_EN_BIT];
            monitor_reset_sel <= wb_dat_w[MON_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Power control and modes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= FLAGS_RESET;
        end else if (!running) begin
            flags_q <= FLAGS_RESET;
        end else if (wr_pc) begin
            flags_q <= wb_dat_w[PC_FLAGS_MSB:PC_FLAGS_LSB]; // [RULE1]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idle_q <= 1'b0;
        end else if (!running) begin
            idle_q <= 1'b0; // [RULE12]
        end else if (wr_pc && wb_dat_w[PC_IDLE_BIT]) begin
            idle_q <= 1'b1; // [RULE4]
        end else if (cpu_irq_taken) begin
            idle_q <= 1'b0; // [RULE12]
        end
    end

    // Stop freezes our own clock too, so only a reset brings it back
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stop_q <= 1'b0;
        end else if (!running) begin
            stop_q <= 1'b0;
        end else if (wr_pc && wb_dat_w[PC_STOP_BIT]) begin
            stop_q <= 1'b1; // [RULE2]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b1;
            osc_run       <= 1'b1;
        end else begin
            cpu_clk_en    <= !idle_q && !stop_q; // [RULE4]
            periph_clk_en <= !stop_q; // [RULE4]
            osc_run       <= !stop_q; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            supply_prev_q <= 1'b0;
        end else begin
            supply_prev_q <= supply_ok;
        end
    end

    assign evt.idle_wake  = running && idle_q && cpu_irq_taken &&
                            !(wr_pc && wb_dat_w[PC_IDLE_BIT]);
    assign evt.supply_low = running && supply_prev_q && !supply_ok;
    assign evt.reset_done = (state_q == ST_DELAY) && (state_d == ST_RUN);

    sticky_bits #(
        .W (3)
    ) u_status (
        .core_clk (core_clk),
        .rstn     (rstn),
        .set      (evt),
        .clr      (wr_stat ? wb_dat_w[2:0] : 3'h0),
        .bits_q   (status_q)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= IRQ_RESET;
        end else if (wr_mask) begin
            mask_q <= wb_dat_w[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        case (bus_idx)
            IDX_POWER_CONTROL: rd_val = {flags_q, 2'b00}; // [RULE3]
            IDX_RESET_SOURCE:  rd_val = {4'h0, cause_q};
            IDX_IRQ_STATUS:    rd_val = {5'h00, status_q};
            IDX_IRQ_MASK:      rd_val = {5'h00, mask_q};
            IDX_MONITOR_CTRL:  rd_val = {6'h00, monitor_reset_sel, monitor_en};
            default:           rd_val = 8'h00;
        endcase
    end

    // Unmapped addresses still answer, reading zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack   <= bus_req;
            wb_dat_r <= (bus_req && !wb_we) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_flags_store: assert property ( // [RULE1]
        wr_pc && running |=> flags_q == $past(wb_dat_w[7:2]))
        else $error("general flags did not store written value");

    a_stop_halts: assert property ( // [RULE2]
        wr_pc && running && wb_dat_w[1] |=> ##1 !osc_run && !cpu_clk_en)
        else $error("stop write did not halt oscillator");

    a_mode_read_zero: assert property ( // [RULE3]
        wb_ack && !wb_we && bus_idx == IDX_POWER_CONTROL |-> wb_dat_r[1:0] == 2'b00)
        else $error("mode bits read back nonzero");

    a_idle_gate: assert property ( // [RULE4]
        wr_pc && running && wb_dat_w[0] && !wb_dat_w[1] && !stop_q
        |=> ##1 !cpu_clk_en && periph_clk_en && osc_run)
        else $error("idle write did not gate only the CPU clock");

    a_hold_pin: assert property ( // [RULE5]
        state_q == ST_HOLD && !supply_ok |=> rst_pin_oe && !rst_pin_out && !cpu_reset_n)
        else $error("reset not held while supply low");

    a_delay_release: assert property ( // [RULE6]
        $rose(cpu_reset_n) |-> $past(state_q) == ST_DELAY && $past(delay_done))
        else $error("reset released without power-up delay");

    a_cause_set: assert property ( // [RULE7]
        $rose(cpu_reset_n) && $past(por_kind_q) |-> cause_q.power_up)
        else $error("power-up cause flag not set");

    a_cause_clear: assert property ( // [RULE8]
        running && state_d == ST_HOLD |=> !cause_q.power_up ##1 !por_kind_q)
        else $error("power-up cause flag not cleared by other reset");

    a_vector_zero: assert property ( // [RULE9]
        $rose(cpu_reset_n) |-> reset_vector == 16'h0000)
        else $error("restart address not zero");

    a_monitor_armed: assert property ( // [RULE11]
        $rose(cpu_reset_n) && $past(por_kind_q) |-> monitor_en && monitor_reset_sel)
        else $error("supply monitor not armed after power-up");

    a_idle_wake: assert property ( // [RULE12]
        running && idle_q && cpu_irq_taken && !wr_pc && !stop_q |=> ##1 cpu_clk_en)
        else $error("interrupt did not end idle");

    a_irq_level: assert property (
        |(status_q & mask_q) |=> irq)
        else $error("unmasked status did not raise interrupt");

endmodule : power_mode_and_por_control

// File: hw/power_pkg.sv
// Constants, register map and carrier types of the power-mode and reset control block
package power_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] IDX_RESET_SOURCE  = 8'h88;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'h89;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'h8A;
    localparam logic [7:0] IDX_MONITOR_CTRL  = 8'h8B;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         PC_IDLE_BIT       = 0;
    localparam int         PC_STOP_BIT       = 1;
    localparam int         PC_FLAGS_LSB      = 2;
    localparam int         PC_FLAGS_MSB      = 7;
    localparam logic [5:0] FLAGS_RESET       = 6'h00;
    localparam int         MON_EN_BIT        = 0;
    localparam int         MON_SEL_BIT       = 1;
    localparam logic [1:0] MON_RESET         = 2'h3;
    localparam logic [2:0] IRQ_RESET         = 3'h0;
    localparam logic [15:0] RESET_VECTOR     = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned POR_DELAY_MS     = 10;
    localparam int unsigned POR_DELAY_CYCLES = POR_DELAY_MS * (CLK_HZ / 1000);
    localparam int          DELAY_W          = 18;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic other;
        logic monitor;
        logic power_up;
        logic pin;
    } reset_cause_s;

    typedef struct packed {
        logic reset_done;
        logic supply_low;
        logic idle_wake;
    } irq_evt_s;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_DELAY,
        ST_RUN
    } seq_state_e;

endpackage : power_pkg

// File: hw/sticky_bits.sv
// Sticky event bits with write-one-to-clear, set winning over clear
`timescale 1ns/100ps
module sticky_bits #(
    parameter int W = 3
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] bits_q
);
    // An event in the clearing cycle survives
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bits_q <= '0;
        end else begin
            bits_q <= (bits_q & ~clr) | set;
        end
    end
endmodule : sticky_bits

// File: hw/delay_counter.sv
// Loadable down counter that flags when it has run out
`timescale 1ns/100ps
module delay_counter #(
    parameter int W = 18
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    logic [W-1:0] count_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign done = (count_q == '0) && !load;
endmodule : delay_counter

// File: test/power_mode_and_por_control_bench.sv
// Self-checking bench for the power-mode and power-on reset control block
`timescale 1ns/100ps
module power_mode_and_por_control_bench;
    import power_pkg::*;

    // ------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------
    // Short delay keeps every reset sequence to a few dozen cycles
    localparam int unsigned DELAY = 20;
    localparam int          LIMIT = 3000;

    logic        core_clk;
    logic        rstn;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [9:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        irq;
    logic        supply_ok;
    logic        other_reset;
    logic        cpu_irq_taken;
    logic        rst_pin_in;
    logic        rst_pin_out;
    logic        rst_pin_oe;
    logic        pin_pull_low;
    logic        cpu_reset_n;
    logic [15:0] reset_vector;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        osc_run;
    logic        monitor_en;
    logic        monitor_reset_sel;
    int          bad_count;
    int          total_checks;
    int          cycles;

    // Open-drain reset pin with a pull-up; the bench may also pull it low
    assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & ~pin_pull_low;

    power_mode_and_por_control #(
        .POR_DELAY (DELAY)
    ) i_dut (
        .core_clk          (core_clk),
        .rstn              (rstn),
        .wb_cyc            (wb_cyc),
        .wb_stb            (wb_stb),
        .wb_we             (wb_we),
        .wb_adr            (wb_adr),
        .wb_sel            (wb_sel),
        .wb_dat_w          (wb_dat_w),
        .wb_dat_r          (wb_dat_r),
        .wb_ack            (wb_ack),
        .irq               (irq),
        .supply_ok         (supply_ok),
        .other_reset       (other_reset),
        .cpu_irq_taken     (cpu_irq_taken),
        .rst_pin_in        (rst_pin_in),
        .rst_pin_out       (rst_pin_out),
        .rst_pin_oe        (rst_pin_oe),
        .cpu_reset_n       (cpu_reset_n),
        .reset_vector      (reset_vector),
        .cpu_clk_en        (cpu_clk_en),
        .periph_clk_en     (periph_clk_en),
        .osc_run           (osc_run),
        .monitor_en        (monitor_en),
        .monitor_reset_sel (monitor_reset_sel)
    );

    always #20 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Outputs are read right after an edge, so they still hold the value registered at the edge before
    task automatic wb_cycle(input logic [7:0] idx, input logic we, input logic [7:0] wdat,
                            output logic [31:0] rdat);
        int n;
        @(posedge core_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'b00};
        wb_sel   <= 4'h1;
        wb_dat_w <= {24'h00_0000, wdat};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rdat = wb_dat_r;
        check("bus_ack", n < 50, 1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_cycle

    task automatic wb_write(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        wb_cycle(idx, 1'b1, d, dummy);
    endtask : wb_write

    task automatic wb_read(input logic [7:0] idx, output logic [31:0] v);
        wb_cycle(idx, 1'b0, 8'h00, v);
    endtask : wb_read

    // Counts edges from the supply becoming good to the CPU leaving reset
    task automatic wait_release;
        int n;
        n = 0;
        while (cpu_reset_n !== 1'b1 && n < DELAY + 10) begin
            @(posedge core_clk);
            n++;
        end
        check("release_not_early", n >= DELAY, 1);
        check("release_not_late", n <= DELAY + 4, 1);
    endtask : wait_release

    // ------------------------------------------------------------
    // Timeout
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic [3:0]  cause;
        logic [7:0]  pats [3];
        pats = '{8'hFC, 8'h54, 8'hA8};
        core_clk = 1'b0; rstn = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
        wb_adr = 10'h000; wb_sel = 4'h0; wb_dat_w = 32'h0000_0000; supply_ok = 1'b0;
        other_reset = 1'b0; cpu_irq_taken = 1'b0; pin_pull_low = 1'b0;
        bad_count = 0; total_checks = 0; cycles = 0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (30) @(posedge core_clk);
        check("hold_cpu", cpu_reset_n, 0);
        check("hold_pin", {rst_pin_oe, rst_pin_out}, 2'b10);
        check("vector", reset_vector, 0);
        supply_ok <= 1'b1;
        wait_release();
        check("pin_released", rst_pin_oe, 0);
        wb_read(IDX_RESET_SOURCE, v);
        check("por_flag", v[1], 1);
        check("mon_pins", {monitor_en, monitor_reset_sel}, 2'b11);
        wb_read(IDX_MONITOR_CTRL, v);
        check("mon_ctrl", v, 32'h0000_0003);
        wb_read(IDX_POWER_CONTROL, v);
        check("pc_reset", v, 32'h0000_0000);
        wb_read(8'hFF, v);
        check("unmapped", v, 32'h0000_0000);
        wb_write(IDX_IRQ_STATUS, 8'h07);
        for (int i = 0; i < 3; i++) begin
            wb_write(IDX_POWER_CONTROL, pats[i]);
            wb_read(IDX_POWER_CONTROL, v);
            check("flags", v, {24'h00_0000, pats[i]});
        end
        // Idle entry, wake by a taken interrupt, interrupt mask and clear
        wb_write(IDX_IRQ_MASK, 8'h01);
        wb_write(IDX_POWER_CONTROL, 8'hA9);
        wb_read(IDX_POWER_CONTROL, v);
        check("idle_reads0", v, 32'h0000_00A8);
        check("idle_clocks", {cpu_clk_en, periph_clk_en, osc_run}, 3'b011);
        check("irq_quiet", irq, 0);
        cpu_irq_taken <= 1'b1;
        @(posedge core_clk);
        cpu_irq_taken <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("idle_wake", cpu_clk_en, 1);
        check("irq_up", irq, 1);
        wb_read(IDX_IRQ_STATUS, v);
        check("wake_event", v[0], 1);
        wb_write(IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge core_clk);
        check("irq_masked", irq, 0);
        wb_write(IDX_IRQ_STATUS, 8'h01);
        wb_read(IDX_IRQ_STATUS, v);
        check("w1c", v[0], 0);
        // Pin, supply monitor and other resets: cause kept, power-up flag cleared
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            case (k)
                0: pin_pull_low <= 1'b1;
                1: supply_ok <= 1'b0;
                default: other_reset <= 1'b1;
            endcase
            repeat (4) @(posedge core_clk);
            check("trip_cpu", {cpu_reset_n, rst_pin_oe}, 2'b01);
            check("trip_vector", reset_vector, 0);
            pin_pull_low <= 1'b0;
            supply_ok    <= 1'b1;
            other_reset  <= 1'b0;
            wait_release();
            cause = (k == 0) ? 4'b0001 : (4'b0001 << (k + 1));
            wb_read(IDX_RESET_SOURCE, v);
            check("cause", v[3:0] & (4'b0010 | cause), cause);
        end
        // Supply fall and the three releases leave their events; monitor can be switched off
        wb_read(IDX_IRQ_STATUS, v);
        check("events", v, 32'h0000_0006);
        wb_write(IDX_MONITOR_CTRL, 8'h00);
        wb_read(IDX_MONITOR_CTRL, v);
        check("mon_off", v, 32'h0000_0000);
        check("mon_off_pins", {monitor_en, monitor_reset_sel}, 2'b00);
        // Stop mode: only a reset brings the oscillator back
        wb_write(IDX_POWER_CONTROL, 8'h02);
        repeat (3) @(posedge core_clk);
        check("stop_clocks", {cpu_clk_en, periph_clk_en, osc_run}, 3'b000);
        wb_read(IDX_POWER_CONTROL, v);
        check("stop_reads0", v, 32'h0000_0000);
        rstn <= 1'b0; // Nothing stored before it is relied on
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check("osc_back", osc_run, 1);
        wait_release();
        wb_read(IDX_RESET_SOURCE, v);
        check("por_again", v[1], 1);
        check("mon_rearmed", {monitor_en, monitor_reset_sel}, 2'b11);
        summarize();
    end

endmodule : power_mode_and_por_control_bench
